// file: hw/debug_trace_gpio_port.sv
// Purpose: eight-pin gpio port with debug and trace functions, AHB-Lite
// Assumes: single word transfers, one slave, hclk at 100 MHz
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Summary of operation
// RULE_01: eight pins, each direction set on its own bit.
// RULE_02: after reset pin 0 is debug data, input, output, pull-up on.
// RULE_03: after reset pin 1 is debug clock, input and pull-down on.
// RULE_04: after reset pins 2 to 7 are plain port, all enables off.
// RULE_05: pin 0 as debug data keeps its driver in stop mode.
// RULE_06: software should return pin 1 to port use when unused.
// RULE_07: data register holds eight bits, reset zero, upper bits zero.
// RULE_08: output enable register, one bit per pin, only bit 0 set.
// RULE_09: function register bits 0 to 6 pick alternate use.
// RULE_10: pull-up register bits 7..2 and 0; bit 1 reads zero.
// RULE_11: pull-down register has only bit 1, reset to one.
// RULE_12: input enable register decoded at its own offset.
// RULE_13: stop mode without drive enable disables pin input and output.
// RULE_14: data read returns pin level where input is enabled.
`timescale 1ns/1ps
module debug_trace_gpio_port #(
  parameter int PINS = gpio_port_pkg::PIN_COUNT
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire logic              stop_mode,
  input  wire logic              drive_enable,
  input  wire logic              debug_data_out,
  input  wire logic              debug_data_oe,
  input  wire logic              trace_clock_out,
  input  wire logic [3:0]        trace_bit_out,
  output logic                   debug_data_in,
  output logic                   debug_clock_in,
  input  wire logic [PINS-1:0]   pin_in,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe,
  output logic      [PINS-1:0]   pin_ie,
  output logic      [PINS-1:0]   pin_pullup,
  output logic      [PINS-1:0]   pin_pulldown
);

  if (PINS != gpio_port_pkg::PIN_COUNT) begin : g_bad_pins
    $error("debug_trace_gpio_port supports exactly eight pins");
  end

  gpio_port_pkg::bus_phase_t phase_r;
  gpio_port_pkg::bus_phase_t phase_nxt;
  gpio_port_pkg::reg_sel_t   sel_r;
  gpio_port_pkg::reg_sel_t   rd_sel;

  logic [PINS-1:0] data_r;
  logic [PINS-1:0] oe_r;
  logic [6:0]      fn_r;
  logic [PINS-1:0] pu_r;
  logic [PINS-1:0] pd_r;
  logic [PINS-1:0] ie_r;
  logic [PINS-1:0] pin_level;
  logic [31:0]     rd_nxt;
  logic            accept;
  logic            wr_en;
  logic            wr_seen_r;

  // unused by a word-only slave
  logic            unused_size;
  assign unused_size = ^hsize;

  assign accept = hsel & hready &
                  ((htrans == gpio_port_pkg::HTRANS_NONSEQ) |
                   (htrans == gpio_port_pkg::HTRANS_SEQ));
  assign wr_en  = (phase_r == gpio_port_pkg::PH_WRITE);
  assign rd_sel = sel_r;

  assign hreadyout = (phase_r != gpio_port_pkg::PH_READ_WAIT);
  assign hresp     = 1'b0;

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      gpio_port_pkg::PH_READ_WAIT: phase_nxt = gpio_port_pkg::PH_READ_DONE;
      gpio_port_pkg::PH_IDLE,
      gpio_port_pkg::PH_WRITE,
      gpio_port_pkg::PH_READ_DONE: begin
        if (accept && hwrite) begin
          phase_nxt = gpio_port_pkg::PH_WRITE;
        end else if (accept) begin
          phase_nxt = gpio_port_pkg::PH_READ_WAIT;
        end else begin
          phase_nxt = gpio_port_pkg::PH_IDLE;
        end
      end
      default: phase_nxt = gpio_port_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= gpio_port_pkg::PH_IDLE;
      sel_r   <= gpio_port_pkg::SEL_NONE;
    end else begin
      phase_r <= phase_nxt;
      if (accept && hreadyout) begin
        sel_r <= gpio_port_pkg::decode_offset(
                   haddr[gpio_port_pkg::OFF_W-1:0]); // RULE_12
      end
    end
  end

  // data latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= gpio_port_pkg::DATA_RST; // RULE_07
    end else if (wr_en && sel_r == gpio_port_pkg::SEL_DATA) begin
      data_r <= hwdata[PINS-1:0]; // RULE_14
    end
  end

  // output enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_r <= gpio_port_pkg::OUT_EN_RST; // RULE_08
    end else if (wr_en && sel_r == gpio_port_pkg::SEL_OUT_EN) begin
      oe_r <= hwdata[PINS-1:0]; // RULE_01
    end
  end

  // function select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_r <= gpio_port_pkg::FUNC_RST; // RULE_02
    end else if (wr_en && sel_r == gpio_port_pkg::SEL_FUNC) begin
      fn_r <= hwdata[gpio_port_pkg::FN_COUNT-1:0]; // RULE_09
    end
  end

  // pulls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pu_r <= gpio_port_pkg::PULLUP_RST;   // RULE_02
      pd_r <= gpio_port_pkg::PULLDOWN_RST; // RULE_03
    end else if (wr_en && sel_r == gpio_port_pkg::SEL_PULLUP) begin
      pu_r <= hwdata[PINS-1:0] & gpio_port_pkg::PULLUP_MASK; // RULE_10
    end else if (wr_en && sel_r == gpio_port_pkg::SEL_PULLDOWN) begin
      pd_r <= hwdata[PINS-1:0] & gpio_port_pkg::PULLDOWN_MASK; // RULE_11
    end
  end

  // input enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ie_r <= gpio_port_pkg::IN_EN_RST; // RULE_04
    end else if (wr_en && sel_r == gpio_port_pkg::SEL_IN_EN) begin
      ie_r <= hwdata[PINS-1:0]; // RULE_12
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (rd_sel)
      gpio_port_pkg::SEL_DATA:
        rd_nxt[PINS-1:0] = (pin_level & ie_r) | (data_r & ~ie_r); // RULE_14
      gpio_port_pkg::SEL_OUT_EN:   rd_nxt[PINS-1:0] = oe_r;
      gpio_port_pkg::SEL_FUNC:     rd_nxt[6:0]      = fn_r;
      gpio_port_pkg::SEL_PULLUP:   rd_nxt[PINS-1:0] = pu_r;
      gpio_port_pkg::SEL_PULLDOWN: rd_nxt[PINS-1:0] = pd_r;
      gpio_port_pkg::SEL_IN_EN:    rd_nxt[PINS-1:0] = ie_r;
      default:                     rd_nxt = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (phase_r == gpio_port_pkg::PH_READ_WAIT) begin
      hrdata <= rd_nxt; // RULE_07
    end
  end

  gpio_pad_ctrl #(
    .PINS (PINS)
  ) u_gpio_pad_ctrl (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .data_r          (data_r),
    .oe_r            (oe_r),
    .fn_r            (fn_r),
    .pu_r            (pu_r),
    .pd_r            (pd_r),
    .ie_r            (ie_r),
    .stop_mode       (stop_mode),
    .drive_enable    (drive_enable),
    .debug_data_out  (debug_data_out),
    .debug_data_oe   (debug_data_oe),
    .trace_clock_out (trace_clock_out),
    .trace_bit_out   (trace_bit_out),
    .pin_in          (pin_in),
    .pin_out         (pin_out),
    .pin_oe          (pin_oe),
    .pin_ie          (pin_ie),
    .pin_pullup      (pin_pullup),
    .pin_pulldown    (pin_pulldown),
    .pin_level       (pin_level),
    .debug_data_in   (debug_data_in),
    .debug_clock_in  (debug_clock_in)
  );

  // helper: no register write yet since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_seen_r <= 1'b0;
    end else if (wr_en) begin
      wr_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_reset_debug_data;
    !wr_seen_r |-> fn_r[0] && oe_r[0] && ie_r[0] && pu_r[0];
  endproperty
  a_reset_debug_data: assert property (p_reset_debug_data) // RULE_02
    else $error("pin 0 not in debug data state after reset");

  property p_reset_debug_clk;
    !wr_seen_r |-> fn_r[1] && !oe_r[1] && ie_r[1] && pd_r[1];
  endproperty
  a_reset_debug_clk: assert property (p_reset_debug_clk) // RULE_03
    else $error("pin 1 not in debug clock state after reset");

  property p_reset_port_pins;
    !wr_seen_r |-> (fn_r[6:2] == '0) && (oe_r[7:2] == '0) &&
                   (ie_r[7:2] == '0) && (pu_r[7:2] == '0);
  endproperty
  a_reset_port_pins: assert property (p_reset_port_pins) // RULE_04
    else $error("pins 2..7 not plain port after reset");

  property p_upper_read_zero;
    phase_r == gpio_port_pkg::PH_READ_DONE |-> hrdata[31:8] == '0;
  endproperty
  a_upper_read_zero: assert property (p_upper_read_zero) // RULE_07
    else $error("reserved read bits not zero");

  property p_oe_write;
    wr_en && sel_r == gpio_port_pkg::SEL_OUT_EN
      |=> oe_r == $past(hwdata[7:0]) ##1
          pin_oe[7:1] == $past(oe_r[7:1]) || $past(stop_mode);
  endproperty
  a_oe_write: assert property (p_oe_write) // RULE_08
    else $error("output enable write not stored");

  property p_fn_write;
    wr_en && sel_r == gpio_port_pkg::SEL_FUNC
      |=> fn_r == $past(hwdata[6:0]) && ie_r == $past(ie_r);
  endproperty
  a_fn_write: assert property (p_fn_write) // RULE_09
    else $error("function write not stored");

  property p_pull_masks;
    !pu_r[1] && (pd_r & ~gpio_port_pkg::PULLDOWN_MASK) == '0;
  endproperty
  a_pull_masks: assert property (p_pull_masks) // RULE_10
    else $error("unimplemented pull bit set");

  property p_pd_write;
    wr_en && sel_r == gpio_port_pkg::SEL_PULLDOWN
      |=> pd_r[1] == $past(hwdata[1]) ##1 pin_pulldown == $past(pd_r);
  endproperty
  a_pd_write: assert property (p_pd_write) // RULE_11
    else $error("pull-down write or pad not following");

  property p_ie_decode;
    wr_en && sel_r == gpio_port_pkg::SEL_IN_EN
      |=> ie_r == $past(hwdata[7:0]) && oe_r == $past(oe_r) &&
          data_r == $past(data_r);
  endproperty
  a_ie_decode: assert property (p_ie_decode) // RULE_12
    else $error("input enable write hit another register");

  property p_stop_debug_drive;
    stop_mode && !drive_enable && fn_r[0] && oe_r[0] && debug_data_oe
      |=> pin_oe[0];
  endproperty
  a_stop_debug_drive: assert property (p_stop_debug_drive) // RULE_05
    else $error("debug data driver dropped in stop mode");

  property p_stop_gate;
    stop_mode && !drive_enable
      |=> pin_ie == '0 && pin_oe[7:1] == '0;
  endproperty
  a_stop_gate: assert property (p_stop_gate) // RULE_13
    else $error("pin left enabled in stop mode");

  property p_port_drive;
    fn_r == '0 && !stop_mode |=> pin_out == $past(data_r) &&
                                 pin_oe == $past(oe_r);
  endproperty
  a_port_drive: assert property (p_port_drive) // RULE_01
    else $error("port pin not following data and enable");

  property p_data_read_pins;
    phase_r == gpio_port_pkg::PH_READ_WAIT &&
    sel_r == gpio_port_pkg::SEL_DATA && ie_r == 8'hff
      |=> hrdata[7:0] == $past(pin_level) ##0 hreadyout;
  endproperty
  a_data_read_pins: assert property (p_data_read_pins) // RULE_14
    else $error("data read did not return pin levels");

endmodule // debug_trace_gpio_port

// file: hw/gpio_port_pkg.sv
// Purpose: shared constants and types for the debug/trace gpio port
// Assumes: 32-bit word-aligned register map, 12-bit offset decode
// Notes:   reset values follow the power-on pin assignment
package gpio_port_pkg;

  localparam int          PIN_COUNT     = 8;
  localparam int          FN_COUNT      = 7;
  localparam int          OFF_W         = 12;
  localparam int          DATA_W        = 32;

  // register offsets (byte addresses)
  localparam logic [11:0] OFF_PIN_DATA  = 12'h000;
  localparam logic [11:0] OFF_OUT_EN    = 12'h004;
  localparam logic [11:0] OFF_FUNC_SEL  = 12'h008;
  localparam logic [11:0] OFF_PULLUP    = 12'h02c;
  localparam logic [11:0] OFF_PULLDOWN  = 12'h030;
  localparam logic [11:0] OFF_IN_EN     = 12'h038;

  // reset values
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [7:0]  OUT_EN_RST    = 8'h01;
  localparam logic [6:0]  FUNC_RST      = 7'h03;
  localparam logic [7:0]  PULLUP_RST    = 8'h01;
  localparam logic [7:0]  PULLDOWN_RST  = 8'h02;
  localparam logic [7:0]  IN_EN_RST     = 8'h03;

  // writable bit masks
  localparam logic [7:0]  PULLUP_MASK   = 8'hfd;
  localparam logic [7:0]  PULLDOWN_MASK = 8'h02;

  // function bit positions
  localparam int          FN_DEBUG_DATA = 0;
  localparam int          FN_DEBUG_CLK  = 1;
  localparam int          FN_TRACE_CLK  = 2;
  localparam int          FN_TRACE_BIT0 = 3;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ    = 2'b11;

  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_DATA     = 3'b001,
    SEL_OUT_EN   = 3'b010,
    SEL_FUNC     = 3'b011,
    SEL_PULLUP   = 3'b100,
    SEL_PULLDOWN = 3'b101,
    SEL_IN_EN    = 3'b110
  } reg_sel_t;

  typedef enum logic [1:0] {
    PH_IDLE      = 2'b00,
    PH_WRITE     = 2'b01,
    PH_READ_WAIT = 2'b10,
    PH_READ_DONE = 2'b11
  } bus_phase_t;

  // offset decode, shared by write and read paths
  function automatic reg_sel_t decode_offset(input logic [11:0] off);
    case (off)
      OFF_PIN_DATA: decode_offset = SEL_DATA;
      OFF_OUT_EN:   decode_offset = SEL_OUT_EN;
      OFF_FUNC_SEL: decode_offset = SEL_FUNC;
      OFF_PULLUP:   decode_offset = SEL_PULLUP;
      OFF_PULLDOWN: decode_offset = SEL_PULLDOWN;
      OFF_IN_EN:    decode_offset = SEL_IN_EN;
      default:      decode_offset = SEL_NONE;
    endcase
  endfunction

endpackage

// file: hw/gpio_pad_ctrl.sv
// Purpose: per-pin function mux, stop-mode gating and pad control flops
// Assumes: pin inputs synchronous to hclk
// Notes:   pad controls are registered, one cycle behind the registers
`timescale 1ns/1ps
module gpio_pad_ctrl #(
  parameter int PINS = 8
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic [PINS-1:0] data_r,
  input  wire logic [PINS-1:0] oe_r,
  input  wire logic [6:0]      fn_r,
  input  wire logic [PINS-1:0] pu_r,
  input  wire logic [PINS-1:0] pd_r,
  input  wire logic [PINS-1:0] ie_r,
  input  wire logic            stop_mode,
  input  wire logic            drive_enable,
  input  wire logic            debug_data_out,
  input  wire logic            debug_data_oe,
  input  wire logic            trace_clock_out,
  input  wire logic [3:0]      trace_bit_out,
  input  wire logic [PINS-1:0] pin_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe,
  output logic      [PINS-1:0] pin_ie,
  output logic      [PINS-1:0] pin_pullup,
  output logic      [PINS-1:0] pin_pulldown,
  output logic      [PINS-1:0] pin_level,
  output logic                 debug_data_in,
  output logic                 debug_clock_in
);

  logic            stop_gate;
  logic [PINS-1:0] out_nxt;
  logic [PINS-1:0] oe_nxt;
  logic [PINS-1:0] ie_nxt;

  assign stop_gate = stop_mode & ~drive_enable;

  always_comb begin
    out_nxt = data_r;
    oe_nxt  = oe_r;
    // alternate functions replace port data on pins 0 and 2..6
    if (fn_r[gpio_port_pkg::FN_DEBUG_DATA]) begin
      out_nxt[0] = debug_data_out;
      oe_nxt[0]  = oe_r[0] & debug_data_oe;
    end
    if (fn_r[gpio_port_pkg::FN_TRACE_CLK]) begin
      out_nxt[2] = trace_clock_out;
    end
    for (int i = 0; i < 4; i++) begin
      if (fn_r[gpio_port_pkg::FN_TRACE_BIT0 + i]) begin
        out_nxt[gpio_port_pkg::FN_TRACE_BIT0 + i] = trace_bit_out[i];
      end
    end
    ie_nxt = ie_r;
    if (stop_gate) begin
      ie_nxt = '0; // RULE_13
      oe_nxt = '0; // RULE_13
      if (fn_r[gpio_port_pkg::FN_DEBUG_DATA]) begin
        oe_nxt[0] = oe_r[0] & debug_data_oe; // RULE_05
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
      pin_ie  <= '0;
    end else begin
      pin_out <= out_nxt; // RULE_01
      pin_oe  <= oe_nxt;  // RULE_01
      pin_ie  <= ie_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_pullup   <= '0;
      pin_pulldown <= '0;
    end else begin
      pin_pullup   <= pu_r;
      pin_pulldown <= pd_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_level      <= '0;
      debug_data_in  <= 1'b0;
      debug_clock_in <= 1'b0;
    end else begin
      pin_level      <= pin_in & ie_nxt; // RULE_14
      debug_data_in  <= pin_in[0] & ie_nxt[0] &
                        fn_r[gpio_port_pkg::FN_DEBUG_DATA];
      debug_clock_in <= pin_in[1] & ie_nxt[1] &
                        fn_r[gpio_port_pkg::FN_DEBUG_CLK];
    end
  end

endmodule // gpio_pad_ctrl

// file: verification/probe_model.sv
// Purpose: pad-side model of the debug probe and trace capture tool
// Assumes: pad controls are registered in the port
// Notes:   an undriven pin without pulls shows a toggling pattern
`timescale 1ns/1ps
module probe_model (
  input  wire logic       hclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] pin_pulldown,
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  output logic      [7:0] pin_in
);
  logic [7:0] float_r;

  initial float_r = 8'h55;

  // floating pins change every cycle so no stale level can pass
  always @(posedge hclk) begin
    float_r <= ~float_r;
  end

  // wire level: port driver, then probe, then pulls, then float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i] === 1'b1) pin_in[i] = pin_out[i];
      else if (drv_en[i]) pin_in[i] = drv_val[i];
      else if (pin_pullup[i] === 1'b1) pin_in[i] = 1'b1;
      else if (pin_pulldown[i] === 1'b1) pin_in[i] = 1'b0;
      else pin_in[i] = float_r[i];
    end
  end
endmodule // probe_model

// file: verification/debug_trace_gpio_port_tb.sv
// Purpose: self-checking bench for the debug/trace gpio port
// Assumes: single AHB-Lite slave, hready tied to hreadyout
// Notes:   pad outputs are checked a few cycles after each change
`timescale 1ns/1ps
module debug_trace_gpio_port_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        stop_mode, drive_enable, debug_data_out, debug_data_oe;
  logic        trace_clock_out, debug_data_in, debug_clock_in;
  logic [3:0]  trace_bit_out;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_ie, pin_pullup, pin_pulldown;
  logic [7:0]  drv_en, drv_val, lv;
  logic [11:0] offs [5];
  logic [31:0] masks [5];
  int          n_fail, n_tests;

  assign hready = hreadyout;

  debug_trace_gpio_port u_debug_trace_gpio_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .stop_mode(stop_mode), .drive_enable(drive_enable),
    .debug_data_out(debug_data_out), .debug_data_oe(debug_data_oe),
    .trace_clock_out(trace_clock_out), .trace_bit_out(trace_bit_out),
    .debug_data_in(debug_data_in), .debug_clock_in(debug_clock_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_ie(pin_ie),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown));

  probe_model u_probe_model (
    .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown),
    .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= gpio_port_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0000_0000, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge hclk);
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    offs  = '{12'h004, 12'h008, 12'h02c, 12'h030, 12'h038};
    masks = '{32'h0000_00ff, 32'h0000_007f, 32'h0000_00fd,
              32'h0000_0002, 32'h0000_00ff};
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; hwrite = 1'b0;
    htrans = 2'b00; hsize = 3'b010; hwdata = 32'h0000_0000;
    stop_mode = 1'b0; drive_enable = 1'b0; debug_data_out = 1'b0;
    debug_data_oe = 1'b0; trace_clock_out = 1'b0; trace_bit_out = 4'h0;
    drv_en = 8'h00; drv_val = 8'h00; n_fail = 0; n_tests = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("pin_oe", pin_oe, 8'h00);
    chk("pin_ie", pin_ie, 8'h03);
    chk("pin_pullup", pin_pullup, 8'h01);
    chk("pin_pulldown", pin_pulldown, 8'h02);
    chk("hresp", hresp, 1'b0);
    rc(12'h000, 32'h0000_0001);
    rc(12'h004, 32'h0000_0001);
    rc(12'h008, 32'h0000_0003);
    rc(12'h02c, 32'h0000_0001);
    rc(12'h030, 32'h0000_0002);
    rc(12'h038, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      wr(offs[i], 32'hffff_ffff);
      rc(offs[i], masks[i]);
      wr(offs[i], 32'h0000_0000);
      rc(offs[i], 32'h0000_0000);
    end
    wr(12'h010, 32'hffff_ffff);
    rc(12'h010, 32'h0000_0000);
    // plain port, mixed per-bit directions
    drv_en <= 8'hff;
    drv_val <= 8'h96;
    wr(12'h004, 32'h0000_005a);
    wr(12'h038, 32'h0000_000f);
    wr(12'h000, 32'hffff_ff3c);
    settle();
    chk("pin_oe", pin_oe, 8'h5a);
    chk("pin_ie", pin_ie, 8'h0f);
    chk("pin_out", pin_out, 8'h3c);
    lv = (8'h3c & 8'h5a) | (8'h96 & ~8'h5a);
    rc(12'h000, {24'h00_0000, (lv & 8'h0f) | (8'h3c & 8'hf0)});
    // trace outputs replace the latch on pins 2 to 6
    wr(12'h008, 32'h0000_007c);
    wr(12'h004, 32'h0000_007c);
    trace_clock_out <= 1'b1;
    trace_bit_out <= 4'ha;
    settle();
    chk("trace pins", pin_out[6:2], 5'h15);
    chk("trace oe", pin_oe, 8'h7c);
    trace_clock_out <= 1'b0;
    trace_bit_out <= 4'h5;
    settle();
    chk("trace pins", pin_out[6:2], 5'h0a);
    // debug pins: probe drives the clock, port drives data
    drv_en <= 8'h02;
    drv_val <= 8'h02;
    debug_data_oe <= 1'b1;
    debug_data_out <= 1'b1;
    wr(12'h008, 32'h0000_0003);
    wr(12'h004, 32'h0000_0001);
    wr(12'h038, 32'h0000_0003);
    settle();
    chk("pin0 oe", pin_oe[0], 1'b1);
    chk("pin0 out", pin_out[0], 1'b1);
    chk("debug_data_in", debug_data_in, 1'b1);
    chk("debug_clock_in", debug_clock_in, 1'b1);
    debug_data_out <= 1'b0;
    drv_val <= 8'h00;
    settle();
    chk("pin0 out", pin_out[0], 1'b0);
    chk("debug_data_in", debug_data_in, 1'b0);
    chk("debug_clock_in", debug_clock_in, 1'b0);
    // stop mode gating
    wr(12'h004, 32'h0000_00ff);
    wr(12'h038, 32'h0000_00ff);
    rc(12'h000, 32'h0000_003c);
    stop_mode <= 1'b1;
    settle();
    chk("stop oe", pin_oe, 8'h01);
    chk("stop ie", pin_ie, 8'h00);
    drive_enable <= 1'b1;
    settle();
    chk("stop oe", pin_oe, 8'hff);
    chk("stop ie", pin_ie, 8'hff);
    drive_enable <= 1'b0;
    debug_data_oe <= 1'b0;
    settle();
    chk("stop oe", pin_oe, 8'h00);
    stop_mode <= 1'b0;
    wr(12'h008, 32'h0000_0000);
    rc(12'h008, 32'h0000_0000);
    give_verdict();
  end
endmodule // debug_trace_gpio_port_tb
